// >>> hdl/flash_err_pkg.sv
// Constants for the host-side flash error status controller.
// Assumes a parallel x16 NOR device strobed by its write and output enables.
package flash_err_pkg;
    localparam int CLK_NS = 4;
    // Strobe width of one bus cycle; a plain default, tune per device grade
    localparam int STROBE_NS = 40;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    // Two flip-flops of input synchronisation lengthen every read strobe
    localparam int SYNC_CYC = 2;
    localparam int PROT_BUSY_MIN_US = 20;
    localparam int PROT_BUSY_MAX_US = 100;
    localparam int PROT_BUSY_MAX_CYC = PROT_BUSY_MAX_US * 1000 / CLK_NS;

    localparam logic [15:0] CMD_SR_READ = 16'h0070;
    localparam logic [15:0] CMD_SR_CLEAR = 16'h0071;
    localparam logic [15:0] CMD_UNLOCK1 = 16'h00aa;
    localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
    localparam logic [15:0] CMD_ABORT_RESET = 16'h00f0;
    localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
    localparam logic [11:0] ADDR_UNLOCK2 = 12'h2aa;

    // status_reg fields
    localparam int SR_VALID = 7;
    localparam int SR_SUSP = 6;
    localparam int SR_ERASE_ERR = 5;
    localparam int SR_PROG_ERR = 4;
    localparam int SR_ABORT = 3;
    localparam int SR_PROT = 1;
    // Polling word fields
    localparam int POLL_ERASE_TIMER = 3;
    localparam int POLL_TOGGLE_B = 2;
    localparam int POLL_ABORT = 1;
endpackage : flash_err_pkg

// >>> hdl/flash_bus_cycle.sv
// Single read or write cycle on the flash parallel pins.
// Assumes one request at a time; data pins are sampled through two flops.
`timescale 1ns/1ns
module flash_bus_cycle
    import flash_err_pkg::*;
#(
    parameter int ADDR_W = 22,
    parameter int DATA_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic req,
    input wire logic wr,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    output logic ack,
    output logic [DATA_W-1:0] rdata,
    output logic [ADDR_W-1:0] fl_addr,
    input wire logic [DATA_W-1:0] fl_dq_in,
    output logic [DATA_W-1:0] fl_dq_out,
    output logic fl_dq_oe_n,
    output logic fl_ce_n,
    output logic fl_oe_n,
    output logic fl_we_n
);
    typedef enum {B_IDLE, B_SETUP, B_STROBE, B_HOLD} bus_state_t;
    bus_state_t state;
    logic is_wr;
    logic [7:0] cnt;
    logic [7:0] last;
    logic [DATA_W-1:0] dq_meta;
    logic [DATA_W-1:0] dq_sync;
    logic [7:0] we_low_cnt;

    if (STROBE_CYC + SYNC_CYC > 255 || STROBE_CYC < 1) begin : g_chk
        $error("strobe length does not fit the cycle counter");
    end

    assign last = is_wr ? 8'(STROBE_CYC - 1) : 8'(STROBE_CYC + SYNC_CYC - 1);

    always_ff @(posedge clk) begin
        dq_meta <= fl_dq_in;
        dq_sync <= dq_meta;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= B_IDLE;
            is_wr <= 1'b0;
            cnt <= 8'h00;
            ack <= 1'b0;
            rdata <= '0;
            fl_addr <= '0;
            fl_dq_out <= '0;
            fl_dq_oe_n <= 1'b1;
            fl_ce_n <= 1'b1;
            fl_oe_n <= 1'b1;
            fl_we_n <= 1'b1;
        end else begin
            ack <= 1'b0;
            case (state)
                B_IDLE: begin
                    if (req) begin
                        is_wr <= wr;
                        fl_addr <= addr;
                        fl_dq_out <= wdata;
                        fl_dq_oe_n <= ~wr;
                        fl_ce_n <= 1'b0;
                        state <= B_SETUP;
                    end
                end
                B_SETUP: begin
                    cnt <= 8'h00;
                    fl_we_n <= ~is_wr;
                    fl_oe_n <= is_wr;
                    state <= B_STROBE;
                end
                B_STROBE: begin
                    if (cnt == last) begin
                        fl_we_n <= 1'b1;
                        fl_oe_n <= 1'b1;
                        if (!is_wr) begin
                            rdata <= dq_sync;
                        end
                        state <= B_HOLD;
                    end else begin
                        cnt <= cnt + 8'h01;
                    end
                end
                B_HOLD: begin
                    fl_ce_n <= 1'b1;
                    fl_dq_oe_n <= 1'b1;
                    ack <= 1'b1;
                    state <= B_IDLE;
                end
                default: state <= B_IDLE;
            endcase
        end
    end

    // Cycles the write strobe has stood low; saturates, never wraps
    always_ff @(posedge clk) begin
        if (rst || fl_we_n) begin
            we_low_cnt <= 8'h00;
        end else if (we_low_cnt != 8'hff) begin
            we_low_cnt <= we_low_cnt + 8'h01;
        end
    end

    // Device latches on the write strobe; it must stand the full width
    property p_we_width;
        @(posedge clk) disable iff (rst)
        $rose(fl_we_n) |-> we_low_cnt == 8'(STROBE_CYC);
    endproperty
    a_we_width: assert property (p_we_width)
        else $error("write strobe width differs from strobe length");
    property p_ack_pulse;
        @(posedge clk) disable iff (rst)
        ack |=> !ack && fl_ce_n;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("bus ack not a single pulse with chip enable high");
endmodule : flash_bus_cycle

// >>> hdl/flash_err_host.sv
// Host controller that checks flash error status and clears an abort error.
// Assumes START follows a program or erase already issued to the device.
`timescale 1ns/1ns
module flash_err_host
    import flash_err_pkg::*;
#(
    parameter int ADDR_W = 22,
    parameter int WAIT_LIMIT = flash_err_pkg::PROT_BUSY_MAX_CYC
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic START,
    input wire logic [ADDR_W-1:0] LAST_ADDR,
    input wire logic CLEAR_USE_SR_CLEAR,
    output logic BUSY,
    output logic DONE,
    output logic [7:0] STATUS,
    output logic [15:0] POLL_WORD,
    output logic ERR_PROT,
    output logic ERR_ABORT,
    output logic TIMEOUT,
    output logic [ADDR_W-1:0] FL_ADDR,
    input wire logic [15:0] FL_DQ_IN,
    output logic [15:0] FL_DQ_OUT,
    output logic FL_DQ_OE_N,
    output logic FL_CE_N,
    output logic FL_OE_N,
    output logic FL_WE_N,
    input wire logic READY_BUSY
);
    typedef enum {H_IDLE, H_SR_CMD, H_SR_RD, H_EVAL, H_POLL_RD, H_CLR,
                  H_RB_WAIT, H_END} host_state_t;
    host_state_t state;
    logic pending;
    logic bus_req;
    logic bus_wr;
    logic [ADDR_W-1:0] bus_addr;
    logic [15:0] bus_wdata;
    logic bus_ack;
    logic [15:0] bus_rdata;
    logic [1:0] clr_step;
    logic [1:0] clr_last;
    logic rb_meta;
    logic rb_sync;
    logic timer_clr;
    logic [31:0] wait_cnt;
    logic timed_out;
    logic [15:0] poll_mask;

    if (ADDR_W < 12 || WAIT_LIMIT < 1) begin : g_chk
        $error("address too narrow for unlock cycles or zero wait limit");
    end

    flash_bus_cycle #(.ADDR_W(ADDR_W), .DATA_W(16)) u_bus (
        .clk(SYS_CLK),
        .rst(RST),
        .req(bus_req),
        .wr(bus_wr),
        .addr(bus_addr),
        .wdata(bus_wdata),
        .ack(bus_ack),
        .rdata(bus_rdata),
        .fl_addr(FL_ADDR),
        .fl_dq_in(FL_DQ_IN),
        .fl_dq_out(FL_DQ_OUT),
        .fl_dq_oe_n(FL_DQ_OE_N),
        .fl_ce_n(FL_CE_N),
        .fl_oe_n(FL_OE_N),
        .fl_we_n(FL_WE_N)
    );

    always_ff @(posedge SYS_CLK) begin
        rb_meta <= READY_BUSY;
        rb_sync <= rb_meta;
    end

    // One window covers the longest protection busy time
    assign timed_out = wait_cnt >= 32'(WAIT_LIMIT);
    always_ff @(posedge SYS_CLK) begin
        if (RST || timer_clr || state == H_IDLE) begin
            wait_cnt <= 32'h0;
        end else if (!timed_out) begin
            wait_cnt <= wait_cnt + 32'h1;
        end
    end

    // Erase timer and toggle b carry nothing without a suspended erase
    always_comb begin
        poll_mask = 16'hffff;
        if (!STATUS[SR_SUSP]) begin
            poll_mask[POLL_ERASE_TIMER] = 1'b0;
            poll_mask[POLL_TOGGLE_B] = 1'b0;
        end
    end

    assign clr_last = CLEAR_USE_SR_CLEAR ? 2'd0 : 2'd2;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state <= H_IDLE;
            pending <= 1'b0;
            bus_req <= 1'b0;
            bus_wr <= 1'b0;
            bus_addr <= '0;
            bus_wdata <= 16'h0000;
            clr_step <= 2'd0;
            timer_clr <= 1'b0;
            BUSY <= 1'b0;
            DONE <= 1'b0;
            STATUS <= 8'h00;
            POLL_WORD <= 16'h0000;
            ERR_PROT <= 1'b0;
            ERR_ABORT <= 1'b0;
            TIMEOUT <= 1'b0;
        end else begin
            bus_req <= 1'b0;
            DONE <= 1'b0;
            timer_clr <= 1'b0;
            case (state)
                H_IDLE: begin
                    if (START) begin
                        BUSY <= 1'b1;
                        ERR_PROT <= 1'b0;
                        ERR_ABORT <= 1'b0;
                        TIMEOUT <= 1'b0;
                        state <= H_SR_CMD;
                    end
                end
                H_SR_CMD: begin
                    // Only the status read may go out while busy
                    if (!pending) begin
                        bus_req <= 1'b1;
                        bus_wr <= 1'b1;
                        bus_addr <= ADDR_W'(ADDR_UNLOCK1);
                        bus_wdata <= CMD_SR_READ;
                        pending <= 1'b1;
                    end else if (bus_ack) begin
                        pending <= 1'b0;
                        state <= H_SR_RD;
                    end
                end
                H_SR_RD: begin
                    if (!pending) begin
                        bus_req <= 1'b1;
                        bus_wr <= 1'b0;
                        pending <= 1'b1;
                    end else if (bus_ack) begin
                        pending <= 1'b0;
                        STATUS <= bus_rdata[7:0];
                        state <= H_EVAL;
                    end
                end
                H_EVAL: begin
                    if (!STATUS[SR_VALID]) begin
                        // Not ready: keep polling, bounded by the window
                        if (timed_out) begin
                            TIMEOUT <= 1'b1;
                            state <= H_END;
                        end else begin
                            state <= H_SR_CMD;
                        end
                    end else if (STATUS[SR_ABORT]) begin
                        ERR_ABORT <= 1'b1;
                        state <= H_POLL_RD;
                    end else begin
                        ERR_PROT <= STATUS[SR_PROT];
                        timer_clr <= 1'b1;
                        state <= H_RB_WAIT;
                    end
                end
                H_POLL_RD: begin
                    // Status read leaves the abort overlay in place
                    if (!pending) begin
                        bus_req <= 1'b1;
                        bus_wr <= 1'b0;
                        bus_addr <= LAST_ADDR;
                        pending <= 1'b1;
                    end else if (bus_ack) begin
                        pending <= 1'b0;
                        POLL_WORD <= bus_rdata & poll_mask;
                        clr_step <= 2'd0;
                        state <= H_CLR;
                    end
                end
                H_CLR: begin
                    if (!pending) begin
                        bus_req <= 1'b1;
                        bus_wr <= 1'b1;
                        pending <= 1'b1;
                        if (CLEAR_USE_SR_CLEAR) begin
                            bus_addr <= ADDR_W'(ADDR_UNLOCK1);
                            bus_wdata <= CMD_SR_CLEAR;
                        end else begin
                            case (clr_step)
                                2'd0: begin
                                    bus_addr <= ADDR_W'(ADDR_UNLOCK1);
                                    bus_wdata <= CMD_UNLOCK1;
                                end
                                2'd1: begin
                                    bus_addr <= ADDR_W'(ADDR_UNLOCK2);
                                    bus_wdata <= CMD_UNLOCK2;
                                end
                                default: begin
                                    bus_addr <= ADDR_W'(ADDR_UNLOCK1);
                                    bus_wdata <= CMD_ABORT_RESET;
                                end
                            endcase
                        end
                    end else if (bus_ack) begin
                        pending <= 1'b0;
                        if (clr_step == clr_last) begin
                            timer_clr <= 1'b1;
                            state <= H_RB_WAIT;
                        end else begin
                            clr_step <= clr_step + 2'd1;
                        end
                    end
                end
                H_RB_WAIT: begin
                    if (rb_sync) begin
                        state <= H_END;
                    end else if (timed_out) begin
                        TIMEOUT <= 1'b1;
                        state <= H_END;
                    end
                end
                H_END: begin
                    BUSY <= 1'b0;
                    DONE <= 1'b1;
                    state <= H_IDLE;
                end
                default: state <= H_IDLE;
            endcase
        end
    end

    property p_busy_sr_only;
        @(posedge SYS_CLK) disable iff (RST)
        (bus_req && bus_wr && state == H_SR_CMD) |-> bus_wdata == CMD_SR_READ;
    endproperty
    a_busy_sr_only: assert property (p_busy_sr_only)
        else $error("command other than status read while busy");

    property p_clear_cmd;
        @(posedge SYS_CLK) disable iff (RST)
        (bus_req && state == H_CLR && clr_step == clr_last) |->
            bus_wdata == (CLEAR_USE_SR_CLEAR ? CMD_SR_CLEAR : CMD_ABORT_RESET);
    endproperty
    a_clear_cmd: assert property (p_clear_cmd)
        else $error("abort cleared with wrong command");

    property p_abort_cleared;
        @(posedge SYS_CLK) disable iff (RST)
        (DONE && ERR_ABORT && !TIMEOUT) |-> $past(state, 2) == H_RB_WAIT;
    endproperty
    a_abort_cleared: assert property (p_abort_cleared)
        else $error("abort finished without clear and ready wait");

    property p_mask_timer;
        @(posedge SYS_CLK) disable iff (RST)
        (DONE && ERR_ABORT && !STATUS[SR_SUSP]) |-> !POLL_WORD[POLL_ERASE_TIMER];
    endproperty
    a_mask_timer: assert property (p_mask_timer)
        else $error("erase timer bit not masked");

    property p_mask_toggle;
        @(posedge SYS_CLK) disable iff (RST)
        (DONE && ERR_ABORT && !STATUS[SR_SUSP]) |-> !POLL_WORD[POLL_TOGGLE_B];
    endproperty
    a_mask_toggle: assert property (p_mask_toggle)
        else $error("toggle b not masked");

    property p_done_after_busy;
        @(posedge SYS_CLK) disable iff (RST)
        DONE |-> !BUSY ##1 !DONE;
    endproperty
    a_done_after_busy: assert property (p_done_after_busy)
        else $error("done not a single pulse after busy drops");

    c_abort: cover property (@(posedge SYS_CLK) DONE && ERR_ABORT);
    c_prot: cover property (@(posedge SYS_CLK) DONE && ERR_PROT);
    c_timeout: cover property (@(posedge SYS_CLK) DONE && TIMEOUT);
    c_sr_clear: cover property (@(posedge SYS_CLK)
        DONE && ERR_ABORT && CLEAR_USE_SR_CLEAR);
endmodule : flash_err_host

// >>> dv/flash_dev_model.sv
// Behavioural parallel flash that reports protection and buffer abort errors.
// Assumes one host with active-low strobes and x16 words, command in low byte.
`timescale 1ns/1ns
module flash_dev_model (
    input wire logic [21:0] addr,
    input wire logic [15:0] dq_from_host,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    output logic [15:0] dq_to_host,
    output logic ready_busy,
    input wire logic arm,
    input wire logic [1:0] fault,
    input wire logic erase_op,
    input wire logic susp,
    input wire logic [15:0] last_word,
    input wire logic [31:0] busy_ns,
    output logic bad_cmd
);
    logic [1:0] st = 2'd0;
    logic [7:0] sr = 8'h80;
    logic [15:0] rd = 16'h0000;
    logic drv = 1'b0;
    logic sr_rd = 1'b0;
    logic tog = 1'b0;
    logic [1:0] unl = 2'd0;
    logic [7:0] cmd;
    logic at555;
    initial ready_busy = 1'b1;
    initial bad_cmd = 1'b0;
    assign cmd = dq_from_host[7:0];
    assign at555 = addr[11:0] == 12'h555;
    // Released bus shows the inverse so a stale read cannot pass
    assign dq_to_host = drv ? rd : ~rd;

    always @(posedge arm) begin
        st = fault;
        unl = 2'd0;
        ready_busy = 1'b0;
        if (fault == 2'd1) begin
            sr = 8'h00;
            #(busy_ns);
            sr = {1'b1, susp, erase_op, !erase_op, 4'b0010};
            st = 2'd0;
            ready_busy = 1'b1;
        end else begin
            sr = {1'b1, susp, 6'b011000};
        end
    end

    always @(posedge we_n) begin
        if (!ce_n) begin
            if (cmd == 8'h70 && at555) begin
                sr_rd = 1'b1;
            end else if (st == 2'd2 && at555 &&
                (cmd == 8'h71 || (unl == 2'd2 && cmd == 8'hf0))) begin
                sr = {1'b1, susp, 6'b000000};
                st = 2'd0;
                ready_busy = 1'b1;
            end else if (st == 2'd2 && cmd == 8'haa) begin
                unl = 2'd1;
            end else if (st == 2'd2 && unl == 2'd1 && cmd == 8'h55) begin
                unl = 2'd2;
            end else if (st != 2'd0) begin
                bad_cmd = 1'b1;
            end
        end
    end

    always @(negedge oe_n) begin
        if (!ce_n) begin
            tog = ~tog;
            drv = 1'b1;
            if (sr_rd) begin
                rd = {8'h00, sr};
            end else if (st == 2'd1) begin
                rd = {8'h00, ~last_word[7] & !erase_op, tog, 1'b0, tog,
                      1'b1, tog, 1'b0, tog};
            end else if (st == 2'd2) begin
                rd = {8'h00, ~last_word[7], tog, 1'b0, tog,
                      susp, tog, 1'b1, tog};
            end else begin
                rd = addr[15:0];
            end
        end
    end

    always @(posedge oe_n) begin
        if (drv) begin
            sr_rd = 1'b0;
        end
        drv = 1'b0;
    end
endmodule : flash_dev_model

// >>> dv/tb_top.sv
// Self-checking bench for the host-side flash error status controller.
// Assumes the behavioural flash model of flash_dev_model.sv on the pins.
`timescale 1ns/1ns
module tb_top;
    import flash_err_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic use_clr = 1'b0;
    logic [21:0] last_addr = 22'h000123;
    logic busy, done, err_prot, err_abort, timeout;
    logic [7:0] status;
    logic [15:0] poll_word, dq_in, dq_out, last_word = 16'h0000;
    logic [21:0] fl_addr;
    logic dq_oe_n, ce_n, oe_n, we_n, ready_busy, bad_cmd;
    logic arm = 1'b0;
    logic erase_op = 1'b0;
    logic susp = 1'b0;
    logic [1:0] fault = 2'd0;
    int busy_ns = 0;
    int error_cnt = 0;
    int samples_checked = 0;

    flash_err_host #(.ADDR_W(22), .WAIT_LIMIT(400)) flash_err_host_i (
        .SYS_CLK(clk), .RST(rst), .START(start), .LAST_ADDR(last_addr),
        .CLEAR_USE_SR_CLEAR(use_clr), .BUSY(busy), .DONE(done),
        .STATUS(status), .POLL_WORD(poll_word), .ERR_PROT(err_prot),
        .ERR_ABORT(err_abort), .TIMEOUT(timeout), .FL_ADDR(fl_addr),
        .FL_DQ_IN(dq_in), .FL_DQ_OUT(dq_out), .FL_DQ_OE_N(dq_oe_n),
        .FL_CE_N(ce_n), .FL_OE_N(oe_n), .FL_WE_N(we_n),
        .READY_BUSY(ready_busy)
    );

    flash_dev_model flash_dev_model_i (
        .addr(fl_addr), .dq_from_host(dq_out), .ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .dq_to_host(dq_in), .ready_busy(ready_busy),
        .arm(arm), .fault(fault), .erase_op(erase_op), .susp(susp),
        .last_word(last_word), .busy_ns(busy_ns), .bad_cmd(bad_cmd)
    );

    initial begin
        forever #2 clk = ~clk;
    end

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic report_and_stop;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // One error episode on the device, then one host check/clear run
    task automatic run_case(input logic [1:0] f, input logic er,
            input logic sp, input logic clr, input logic [15:0] lw,
            input int bns, input logic [7:0] exp_st, input logic exp_to);
        int n;
        logic [15:0] mask;
        @(posedge clk);
        #1;
        fault = f;
        erase_op = er;
        susp = sp;
        use_clr = clr;
        last_word = lw;
        busy_ns = bns;
        arm = 1'b1;
        @(posedge clk);
        #1;
        arm = 1'b0;
        start = 1'b1;
        @(posedge clk);
        #1;
        start = 1'b0;
        check("busy_on", {15'h0, busy}, 16'h0001);
        n = 0;
        while (done !== 1'b1 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        check("done", {15'h0, done}, 16'h0001);
        check("timeout", {15'h0, timeout}, {15'h0, exp_to});
        if (!exp_to) begin
            check("status", {8'h00, status}, {8'h00, exp_st});
        end
        check("err_prot", {15'h0, err_prot},
              {15'h0, f == 2'd1 && !exp_to});
        check("err_abort", {15'h0, err_abort}, {15'h0, f == 2'd2});
        if (f == 2'd2) begin
            mask = sp ? 16'h00aa : 16'h00ae;
            check("poll", poll_word & mask, {8'h00, ~lw[7], 3'b000, sp,
                  3'b010});
        end
        n = 0;
        while (ready_busy !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        check("ready", {15'h0, ready_busy}, 16'h0001);
        check("refused", {15'h0, bad_cmd}, 16'h0000);
        check("mode", {14'h0, flash_dev_model_i.st}, 16'h0000);
        check("resume", {15'h0, flash_dev_model_i.sr[6]},
              {15'h0, sp});
        check("busy", {15'h0, busy}, 16'h0000);
    endtask : run_case

    initial begin
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        run_case(2'd1, 1'b0, 1'b0, 1'b0, 16'h0080, 1000, 8'h92, 1'b0);
        run_case(2'd1, 1'b1, 1'b1, 1'b0, 16'h0000, 1200, 8'he2, 1'b0);
        run_case(2'd2, 1'b0, 1'b0, 1'b0, 16'h0000, 0, 8'h98, 1'b0);
        run_case(2'd2, 1'b0, 1'b1, 1'b1, 16'h0080, 0, 8'hd8, 1'b0);
        run_case(2'd1, 1'b0, 1'b0, 1'b0, 16'h0000, 3000, 8'h00, 1'b1);
        run_case(2'd1, 1'b0, 1'b0, 1'b1, 16'h0000, 200, 8'h92, 1'b0);
        report_and_stop();
    end

    initial begin
        #100000;
        error_cnt++;
        report_and_stop();
    end
endmodule : tb_top
